// *** design/pbwb_pkg.sv ***
// Package: constants and types for the peripheral bus wait bridge
package pbwb_pkg;
	// Register map of the bridge's own port (byte addresses, four apart)
	localparam logic [7:0] PBWB_ADDR_WAIT_CTRL = 8'h00;
	localparam logic [7:0] PBWB_ADDR_WDT_MODE = 8'h04;
	localparam logic [7:0] PBWB_ADDR_STATUS = 8'h08;
	localparam logic [7:0] PBWB_ADDR_LAST_COUNT = 8'h0C;
	// Reset values
	localparam logic [7:0] PBWB_WAIT_CTRL_RESET = 8'h77;
	localparam logic [7:0] PBWB_WDT_MODE_RESET = 8'h00;
	// Field positions of the wait control register
	localparam int PBWB_UPPER_LSB = 4;
	localparam int PBWB_LOWER_LSB = 0;
	localparam int PBWB_NIBBLE_W = 4;
	// Status register bit positions
	localparam int PBWB_ST_BUSY = 0;
	localparam int PBWB_ST_HUNG = 1;
	localparam int PBWB_ST_WDT_RUN = 2;
	// Base access length and the offset added to j before the k factor, in CPU clocks
	localparam logic [7:0] PBWB_BASE_CLOCKS = 8'h03;
	localparam logic [7:0] PBWB_K_OFFSET = 8'h02;
	// Extra-wait factors
	localparam logic [1:0] PBWB_K_WDT = 2'h3;
	localparam logic [1:0] PBWB_K_RTO = 2'h1;
	localparam logic [1:0] PBWB_K_NONE = 2'h0;
	// Peripheral address classes, as decoded by the system
	typedef enum logic [2:0]
	{
		PBWB_CLS_PLAIN = 3'b000,
		PBWB_CLS_WDT_MODE = 3'b001,
		PBWB_CLS_RTO_BUF = 3'b010,
		PBWB_CLS_TIMER = 3'b011,
		PBWB_CLS_RATIO = 3'b100
	} pbwb_class_t;
	typedef enum logic [1:0]
	{
		PBWB_IDLE = 2'b00,
		PBWB_WAIT = 2'b01,
		PBWB_DONE = 2'b10,
		PBWB_HUNG = 2'b11
	} pbwb_state_t;
endpackage : pbwb_pkg

// *** design/pbwb_cnt_if.sv ***
// Interface: wait count request between bridge and its counter
interface pbwb_cnt_if;
	logic start;
	logic [7:0] count;
	logic busy;
	logic done;
	modport ctl (output start, output count, input busy, input done);
	modport cnt (input start, input count, output busy, output done);
endinterface : pbwb_cnt_if

// *** design/pbwb_wait_counter.sv ***
// Module: down counter that times one peripheral access
module pbwb_wait_counter
	import pbwb_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_sync_b,
	input wire logic freeze,
	pbwb_cnt_if.cnt cnt
);
	logic [7:0] remain;
	logic [7:0] next_remain;
	// Freeze holds the count while asserted; a start or a reset still reloads it
	assign next_remain = cnt.start ? cnt.count - 8'h01 :
		(remain != 8'h00 && !freeze) ? remain - 8'h01 : remain;
	assign cnt.busy = (remain != 8'h00);
	assign cnt.done = (remain == 8'h01) && !freeze;
	always_ff @(posedge clk_sys or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
			remain <= 8'h00;
		else
			remain <= next_remain;
	end
endmodule : pbwb_wait_counter

// *** design/pbwb_bridge.sv ***
// Module: CPU to peripheral bus bridge with programmable access waits
// Behaviour
// - Access takes at least three clocks
// - Wait control resets to 0x77
// - Wait control accessed as whole byte
// - Clocks = 3 + i + j + (2+j)*k
// - Lower nibble counts 0/1, upper 0
// - Stall CPU until data transferred
// - Running watchdog mode write: k=3
// - Buffer write, output disabled: k=1
// - Timer writes: first 0, continuous 0-3
// - Forbidden clock access hangs until reset
// - Ratio-derived k rounds up
// - Watchdog auto-starts after reset
// - Watchdog mode selects period and clock
module pbwb_bridge
	import pbwb_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_b,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// CPU side access
	input wire logic cpu_req,
	input wire logic cpu_we,
	input wire logic [2:0] cpu_class,
	input wire logic [15:0] cpu_wdata,
	output logic [15:0] cpu_rdata,
	output logic cpu_ack,
	output logic cpu_stall,
	// System state inputs
	input wire logic realtime_output_enable,
	input wire logic clock_forbidden,
	input wire logic [1:0] timer_cont_k,
	input wire logic [7:0] ratio_num,
	input wire logic [7:0] ratio_den,
	// Peripheral side
	output logic per_strobe,
	output logic per_we,
	output logic [15:0] per_wdata,
	input wire logic [15:0] per_rdata,
	// Watchdog control
	output logic watchdog_run,
	output logic [7:0] watchdog_mode_setting
);
	// ----------------------------------------
	// Reset synchroniser
	// ----------------------------------------
	logic rst_meta_b;
	logic rst_sync_b;
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rst_meta_b <= 1'b0;
			rst_sync_b <= 1'b0;
		end
		else
		begin
			rst_meta_b <= 1'b1;
			rst_sync_b <= rst_meta_b;
		end
	end

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------
	// Ceiling division so a fractional factor never shortens the wait
	function automatic logic [7:0] pbwb_ceil_div(input logic [7:0] num, input logic [7:0] den);
		logic [8:0] sum;
		sum = 9'h000;
		if (den == 8'h00)
			pbwb_ceil_div = 8'h00;
		else
		begin
			sum = {1'b0, num} + {1'b0, den} - 9'h001;
			pbwb_ceil_div = 8'(sum / {1'b0, den});
		end
	endfunction : pbwb_ceil_div

	// Nibble contribution: lower counts 1 if any bit is set, upper counts nothing
	function automatic logic [7:0] pbwb_nibble(input logic [3:0] nib, input logic is_lower);
		pbwb_nibble = is_lower ? {7'h00, (nib != 4'h0)} : 8'h00;
	endfunction : pbwb_nibble

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] peripheral_wait_control;
	logic [7:0] last_count;
	logic hung;
	logic prev_timer_write;
	wire wr_wait = reg_wr && (reg_addr == PBWB_ADDR_WAIT_CTRL);
	wire wr_wdt = reg_wr && (reg_addr == PBWB_ADDR_WDT_MODE);

	always_ff @(posedge clk_sys or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
			peripheral_wait_control <= PBWB_WAIT_CTRL_RESET;
		else if (wr_wait)
			peripheral_wait_control <= reg_wdata;
	end

	// watchdog runs from reset; mode selects period and clock
	always_ff @(posedge clk_sys or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
		begin
			watchdog_mode_setting <= PBWB_WDT_MODE_RESET;
			watchdog_run <= 1'b1;
		end
		else if (wr_wdt)
			watchdog_mode_setting <= reg_wdata;
	end

	// ----------------------------------------
	// Wait count computation
	// ----------------------------------------
	wire [7:0] wait_i = pbwb_nibble(peripheral_wait_control[PBWB_UPPER_LSB +: PBWB_NIBBLE_W], 1'b0);
	wire [7:0] wait_j = pbwb_nibble(peripheral_wait_control[PBWB_LOWER_LSB +: PBWB_NIBBLE_W], 1'b1);
	wire is_timer_wr = cpu_we && (cpu_class == PBWB_CLS_TIMER);
	wire [1:0] k_small;
	wire [7:0] k_ratio;
	wire [7:0] k_val;
	assign k_small = (cpu_we && cpu_class == PBWB_CLS_WDT_MODE && watchdog_run) ? PBWB_K_WDT :
		(cpu_we && cpu_class == PBWB_CLS_RTO_BUF && !realtime_output_enable) ? PBWB_K_RTO :
		(is_timer_wr && prev_timer_write) ? timer_cont_k : PBWB_K_NONE;
	assign k_ratio = pbwb_ceil_div(ratio_num, 8'(PBWB_K_OFFSET + wait_j));
	assign k_val = (cpu_class == PBWB_CLS_RATIO) ? k_ratio : {6'h00, k_small};
	wire [15:0] k_prod = 16'((PBWB_K_OFFSET + wait_j) * k_val);
	wire [7:0] total_clocks = 8'(PBWB_BASE_CLOCKS + wait_i + wait_j + k_prod[7:0]);

	// ----------------------------------------
	// Access sequencer
	// ----------------------------------------
	pbwb_state_t state;
	pbwb_state_t next_state;
	pbwb_cnt_if cnt_bus();
	pbwb_wait_counter u_counter (
		.clk_sys(clk_sys),
		.rst_sync_b(rst_sync_b),
		.freeze(hung),
		.cnt(cnt_bus)
	);
	wire start_access = (state == PBWB_IDLE) && cpu_req;
	assign cnt_bus.start = start_access;
	assign cnt_bus.count = total_clocks;

	always_comb
	begin
		next_state = state;
		case (state)
			PBWB_IDLE:
				if (cpu_req)
					next_state = clock_forbidden ? PBWB_HUNG : PBWB_WAIT;
			PBWB_WAIT:
				if (cnt_bus.done)
					next_state = PBWB_DONE;
			PBWB_DONE:
				next_state = PBWB_IDLE;
			PBWB_HUNG:
				next_state = PBWB_HUNG;
			default:
				next_state = PBWB_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
			state <= PBWB_IDLE;
		else
			state <= next_state;
	end

	always_ff @(posedge clk_sys or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
		begin
			hung <= 1'b0;
			prev_timer_write <= 1'b0;
			last_count <= 8'h00;
		end
		else if (start_access)
		begin
			hung <= clock_forbidden;
			prev_timer_write <= is_timer_wr;
			last_count <= total_clocks;
		end
	end

	// ----------------------------------------
	// Peripheral transfer and data capture
	// ----------------------------------------
	// Strobe at the first wait clock, one clock after the access is taken
	always_ff @(posedge clk_sys or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
		begin
			per_strobe <= 1'b0;
			per_we <= 1'b0;
			per_wdata <= 16'h0000;
			cpu_rdata <= 16'h0000;
		end
		else
		begin
			per_strobe <= start_access && !clock_forbidden;
			if (start_access)
			begin
				per_we <= cpu_we;
				per_wdata <= cpu_wdata;
			end
			if (state == PBWB_WAIT && cnt_bus.done)
				cpu_rdata <= per_rdata;
		end
	end

	// stall during wait, one-clock ack at end
	assign cpu_ack = (state == PBWB_DONE);
	assign cpu_stall = (state == PBWB_WAIT) || (state == PBWB_HUNG) || start_access;

	// ----------------------------------------
	// Register read port
	// ----------------------------------------
	wire [7:0] status_val = {5'h00, watchdog_run, hung, (state != PBWB_IDLE)};
	wire [7:0] rd_mux = (reg_addr == PBWB_ADDR_WAIT_CTRL) ? peripheral_wait_control :
		(reg_addr == PBWB_ADDR_WDT_MODE) ? watchdog_mode_setting :
		(reg_addr == PBWB_ADDR_STATUS) ? status_val :
		(reg_addr == PBWB_ADDR_LAST_COUNT) ? last_count : 8'h00;
	always_ff @(posedge clk_sys or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
			reg_rdata <= 8'h00;
		else if (reg_rd)
			reg_rdata <= rd_mux;
		else
			reg_rdata <= 8'h00;
	end
endmodule : pbwb_bridge

// *** tb/pbwb_bridge_chk.sv ***
// Checker: CPU side timing of the peripheral wait bridge
module pbwb_bridge_chk
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic cpu_req,
	input wire logic cpu_we,
	input wire logic [2:0] cpu_class,
	input wire logic cpu_ack,
	input wire logic cpu_stall,
	input wire logic clock_forbidden,
	input wire logic realtime_output_enable,
	input wire logic per_strobe,
	input wire logic watchdog_run
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	sequence s_take;
		$rose(cpu_req) && !clock_forbidden;
	endsequence
	sequence s_hang;
		$rose(cpu_req) && clock_forbidden;
	endsequence
	chk_ack_one_cycle: assert property (cpu_ack |=> !cpu_ack)
		else $error("ack held longer than one cycle");
	chk_three_clock_min: assert property (s_take |-> !cpu_ack[*3])
		else $error("access ended before three clocks");
	chk_stall_while_req: assert property (cpu_req && !cpu_ack |-> cpu_stall)
		else $error("cpu not stalled during access");
	chk_strobe_after_take: assert property (s_take |=> per_strobe)
		else $error("no peripheral strobe after request");
	chk_plain_count: assert property (s_take and (cpu_class == 3'h0) |-> ##[3:4] cpu_ack)
		else $error("plain access count wrong");
	chk_wdt_write_wait: assert property (s_take and (cpu_we && cpu_class == 3'h1)
		|-> !cpu_ack[*8] ##1 !cpu_ack ##[1:5] cpu_ack)
		else $error("watchdog mode write count wrong");
	chk_rto_write_wait: assert property (s_take and (cpu_we && cpu_class == 3'h2
		&& !realtime_output_enable) |-> !cpu_ack[*5] ##[1:3] cpu_ack)
		else $error("buffer write count wrong");
	chk_hang_holds: assert property (s_hang |-> (cpu_stall && !cpu_ack)[*8])
		else $error("forbidden access did not hang");
	chk_wdt_running: assert property (watchdog_run)
		else $error("watchdog not running");
endmodule : pbwb_bridge_chk

bind pbwb_bridge pbwb_bridge_chk u_chk (.clk_sys(clk_sys), .rst_b(rst_b), .cpu_req(cpu_req),
	.cpu_we(cpu_we), .cpu_class(cpu_class), .cpu_ack(cpu_ack), .cpu_stall(cpu_stall),
	.clock_forbidden(clock_forbidden), .realtime_output_enable(realtime_output_enable),
	.per_strobe(per_strobe), .watchdog_run(watchdog_run));

// *** tb/pbwb_periph_model.sv ***
// Peripheral register model on the far side of the bridge
module pbwb_periph_model
(
	input wire logic clk_sys,
	input wire logic per_strobe,
	input wire logic per_we,
	input wire logic [15:0] per_wdata,
	output logic [15:0] per_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] store = 16'h5A3C;
	always_ff @(posedge clk_sys)
	begin
		if (per_strobe && per_we)
			store <= per_wdata;
	end
	assign per_rdata = store;
endmodule : pbwb_periph_model

// *** tb/pbwb_bridge_test.sv ***
// Testbench: self-checking bench of the peripheral wait bridge
module pbwb_bridge_test
	import pbwb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = '0, rst_b = '0, reg_wr = '0, reg_rd = '0, cpu_req = '0, cpu_we = '0;
	logic rto = '0, forbid = '0, cpu_ack, cpu_stall, per_strobe, per_we, wdt_run, j = 1'h1;
	logic [7:0] reg_addr = '0, reg_wdata = '0, ratio = '0, reg_rdata, wdt_mode;
	logic [2:0] cpu_class = '0;
	logic [1:0] tk = '0;
	logic [15:0] cpu_wdata = '0, cpu_rdata, per_wdata, per_rdata, mem = 16'h5A3C;
	logic [31:0] seed = 32'h28;
	logic prev_t = '0;
	int fails = 0, checks = 0;
	always #2 clk_sys = ~clk_sys;
	pbwb_bridge dut (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_class(cpu_class), .cpu_wdata(cpu_wdata),
		.cpu_rdata(cpu_rdata), .cpu_ack(cpu_ack), .cpu_stall(cpu_stall),
		.realtime_output_enable(rto), .clock_forbidden(forbid), .timer_cont_k(tk),
		.ratio_num(ratio), .ratio_den(8'h01), .per_strobe(per_strobe), .per_we(per_we),
		.per_wdata(per_wdata), .per_rdata(per_rdata), .watchdog_run(wdt_run),
		.watchdog_mode_setting(wdt_mode));
	pbwb_periph_model u_per (.clk_sys(clk_sys), .per_strobe(per_strobe), .per_we(per_we),
		.per_wdata(per_wdata), .per_rdata(per_rdata));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	task check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task close_out();
		if (fails == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : close_out
	task do_reset();
		rst_b <= 1'h0;
		repeat (10) @(posedge clk_sys);
		rst_b <= 1'h1;
		repeat (5) @(posedge clk_sys);
	endtask : do_reset
	task reg_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge clk_sys);
		reg_wr <= 1'h0;
		if (a == PBWB_ADDR_WAIT_CTRL)
			j = d[3:0] != 4'h0;
	endtask : reg_write
	task reg_read(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clk_sys);
		reg_rd <= 1'h0;
		@(negedge clk_sys);
		d = reg_rdata;
	endtask : reg_read
	task access(input logic [2:0] cls, input logic we);
		int n, k;
		logic [15:0] d;
		d = rnd();
		@(posedge clk_sys);
		k = (cls == 3'h1 && we) ? 3 : (cls == 3'h2 && we && !rto) ? 1 : 0;
		if (cls == 3'h3 && we && prev_t)
			k = tk;
		if (cls == 3'h4)
			k = (ratio + 1 + j) / (2 + j);
		cpu_req <= 1'h1;
		cpu_we <= we;
		cpu_class <= cls;
		cpu_wdata <= d;
		n = 0;
		@(negedge clk_sys);
		while (cpu_ack !== 1'h1 && n < 400)
		begin
			n++;
			@(negedge clk_sys);
		end
		if (n >= 400)
		begin
			fails++;
			close_out();
		end
		check(16'(n), 16'(3 + j + (2 + j) * k), "access clocks");
		if (!we)
			check(cpu_rdata, mem, "read data");
		else
			mem = d;
		prev_t = cls == 3'h3 && we;
		@(posedge clk_sys);
		cpu_req <= 1'h0;
	endtask : access
	initial
	begin
		logic [7:0] v;
		do_reset();
		reg_read(PBWB_ADDR_WAIT_CTRL, v);
		check(16'(v), 16'(PBWB_WAIT_CTRL_RESET), "wait ctrl reset");
		reg_read(PBWB_ADDR_STATUS, v);
		check(16'(v[PBWB_ST_WDT_RUN]), 16'h1, "watchdog auto start");
		access(3'h0, 1'h0);
		// Setup order: wait control, then watchdog mode, after the first plain read access
		// bus pins would only be switched after this setup
		reg_write(PBWB_ADDR_WAIT_CTRL, 8'h50);
		reg_write(PBWB_ADDR_WDT_MODE, 8'h2A);
		reg_read(PBWB_ADDR_WAIT_CTRL, v);
		check(16'(v), 16'h50, "wait ctrl byte");
		reg_read(PBWB_ADDR_WDT_MODE, v);
		check(16'(v), 16'h2A, "watchdog mode");
		reg_read(8'h10, v);
		check(16'(v), 16'h0, "unmapped read");
		access(3'h0, 1'h1);
		access(3'h0, 1'h0);
		tk <= 2'h3;
		access(3'h3, 1'h1);
		access(3'h3, 1'h1);
		repeat (80)
		begin
			if (rnd() % 6 == 0)
				reg_write(PBWB_ADDR_WAIT_CTRL, 8'(rnd()));
			@(posedge clk_sys);
			rto <= rnd() % 2;
			tk <= 2'(rnd());
			// Kept below 128 so the 8-bit access count cannot wrap
			ratio <= {1'b0, 7'(rnd())};
			access(3'(rnd() % 5), 1'(rnd()));
		end
		// Forbidden clock state: stall until reset
		@(posedge clk_sys);
		forbid <= 1'h1;
		cpu_req <= 1'h1;
		cpu_class <= 3'h0;
		repeat (40) @(posedge clk_sys);
		reg_read(PBWB_ADDR_STATUS, v);
		check(16'(v[PBWB_ST_HUNG]), 16'h1, "hung flag");
		check(16'({cpu_stall, cpu_ack}), 16'h2, "hung stall");
		cpu_req <= 1'h0;
		forbid <= 1'h0;
		prev_t = 1'h0;
		j = 1'h1;
		do_reset();
		access(3'h0, 1'h0);
		close_out();
	end
endmodule : pbwb_bridge_test
